// ==== gpc_defines.vh ====
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// port geometry
`define GPC_W            32
`define GPC_CN_W         31
`define GPC_RMP_W        26
// pins present on this variant (arbitrary default: all)
`define GPC_IMPL_MASK    32'hFFFFFFFF

// register byte offsets
`define GPC_OFF_DIR      8'h00
`define GPC_OFF_LAT      8'h04
`define GPC_OFF_PIN      8'h08
`define GPC_OFF_ODC      8'h0C
`define GPC_OFF_CNEN_LO  8'h10
`define GPC_OFF_CNEN_HI  8'h14
`define GPC_OFF_PU_LO    8'h18
`define GPC_OFF_PU_HI    8'h1C
`define GPC_OFF_ANA      8'h20
`define GPC_OFF_RMP      8'h24
`define GPC_OFF_CNSTAT   8'h28

// reset values
`define GPC_RST_DIR      32'hFFFFFFFF
`define GPC_RST_ZERO     32'h00000000

// bus responses
`define GPC_RESP_OKAY    2'h0
`define GPC_RESP_SLVERR  2'h2

`endif

// ==== gpc_port.v ====
`timescale 1ns/100ps
// Behaviour
// R01 - actively driving enabled peripheral disables port output driver; pin stays readable
// R02 - enabled but idle peripheral leaves the pin to the port output logic
// R03 - port output never loops back into the input of a sharing peripheral
// R04 - direction bit 1 makes the pin input, 0 makes it output
// R05 - every reset sets all direction bits so all pins are inputs
// R06 - latch register reads the latch; writing it updates only the latch
// R07 - pin level register reads pin states; writing it updates the latch
// R08 - unimplemented bits read zero in latch, direction, pin level and are disabled
// R09 - open-drain bit set drives only low and releases high
// R10 - pins configured analog read as 0 from the pin level register
// R11 - software keeps analog pins set as inputs
// R12 - software waits one cycle between port write and read of same port
// R13 - change detect works without clock and raises an interrupt request
// R14 - up to 31 change notification inputs
// R15 - notify enable bit lets that pin's change reach the request
// R16 - pull-up enable bit switches that pin's weak pull-up on
// R17 - software disables pull-ups on pins used as digital outputs
// R18 - remapping available on up to 26 designated pins
// R19 - remappable peripheral reaches a pin only after software assigns it
// R20 - compare enabled pins with captured levels and OR mismatches into one request

`include "gpc_defines.vh"

module gpc_port (
  input  wire        i_clk_sys,     // system clock, 10 MHz
  input  wire        i_rst_n,       // async reset, active low
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output wire        s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire        s_axi_wvalid,  // write data valid
  output wire        s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [7:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output wire        s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  // pins
  input  wire [31:0] i_pin,         // pin levels
  output wire [31:0] o_pin_out,     // pin output value
  output wire [31:0] o_pin_oe,      // pin output enable, high drives
  output wire [31:0] o_pin_pu,      // weak pull-up enable per pin
  // fixed-pin peripherals
  input  wire [31:0] i_per_en,      // peripheral enabled on pin
  input  wire [31:0] i_per_drv,     // peripheral actively driving pin
  input  wire [31:0] i_per_out,     // peripheral output value
  output wire [31:0] o_per_in,      // pin level towards peripheral
  // remappable peripherals on pins 0..25
  input  wire [25:0] i_rmp_drv,     // remapped peripheral driving pin
  input  wire [25:0] i_rmp_out,     // remapped peripheral output value
  output wire [25:0] o_rmp_in,      // pin level towards remapped peripheral
  // change notification
  output wire        o_cn_irq       // change notification request, level
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // software-visible port registers
  reg  [31:0] dir_q;
  reg  [31:0] lat_q;
  reg  [31:0] odc_q;
  reg  [15:0] cnen_lo_q;
  reg  [14:0] cnen_hi_q;
  reg  [15:0] pu_lo_q;
  reg  [14:0] pu_hi_q;
  reg  [31:0] ana_q;
  reg  [25:0] rmp_q;
  // pin levels captured when software last looked
  reg  [30:0] cn_cap_q;
  // write channel halves held until both are in
  reg  [7:0]  awaddr_q;
  reg         aw_full_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_full_q;

  // implemented-pin mask; absent bits are forced off at every output except o_rmp_in and in the direction, latch, open-drain and analog registers
  wire [31:0] impl      = `GPC_IMPL_MASK;
  wire [30:0] cn_en     = {cnen_hi_q, cnen_lo_q};
  wire [25:0] rmp_own;
  wire [31:0] per_own;
  wire [31:0] port_drv;
  wire [31:0] drv_val;
  wire [31:0] drv_on;
  wire [31:0] pin_rd;
  // bus handshake strobes
  wire        wr_go;
  wire        rd_go;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge a bus write into a register under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // true for an offset that holds a register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `GPC_OFF_CNSTAT);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // narrow register merge

  // merge at full width, then keep only the lanes a register really has
  wire [31:0] cnen_lo_wr = merge({16'h0000, cnen_lo_q}, wdata_q, wstrb_q);
  wire [31:0] cnen_hi_wr = merge({17'h00000, cnen_hi_q}, wdata_q, wstrb_q);
  wire [31:0] pu_lo_wr   = merge({16'h0000, pu_lo_q}, wdata_q, wstrb_q);
  wire [31:0] pu_hi_wr   = merge({17'h00000, pu_hi_q}, wdata_q, wstrb_q);
  wire [31:0] rmp_wr     = merge({6'h00, rmp_q}, wdata_q, wstrb_q);

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership and drive

  // remapped peripheral owns the pin only once assigned and driving
  assign rmp_own  = rmp_q & i_rmp_drv;                               // R19 R18
  // a fixed peripheral is ignored on a pin handed to a remapped one
  assign per_own  = {6'h00, rmp_own} |
                    (i_per_en & i_per_drv & ~{6'h00, rmp_q});        // R01 R02
  // port drives an output-direction pin nobody else owns
  assign port_drv = ~dir_q & ~per_own & impl;                        // R04 R08
  assign drv_val  = rmp_own_mux(rmp_own, i_rmp_out, per_own, i_per_out, lat_q);
  // open drain drives only low, releases high
  assign drv_on   = (per_own | port_drv) & impl & ~(odc_q & drv_val); // R09
  assign o_pin_oe  = drv_on;
  assign o_pin_out = drv_val & ~odc_q & drv_on;                      // R09

  // pick the output value from the owner of each pin
  // priority: remapped peripheral, then fixed peripheral, then latch
  function [31:0] rmp_own_mux;
    input [25:0] ro;
    input [25:0] rv;
    input [31:0] po;
    input [31:0] pv;
    input [31:0] lv;
    begin
      rmp_own_mux = (po & pv) | (~po & lv);
      rmp_own_mux[25:0] = (ro & rv) | (~ro & rmp_own_mux[25:0]);
    end
  endfunction

  // port-driven pins read as zero towards peripherals
  assign o_per_in = i_pin & ~port_drv & ~{6'h00, rmp_q} & impl;      // R03
  assign o_rmp_in = i_pin[25:0] & ~port_drv[25:0] & rmp_q;           // R03 R19

  // pull-ups only on notification-capable pins
  // bit 31 has no notify input, so it never gets a pull-up
  assign o_pin_pu = {1'b0, pu_hi_q, pu_lo_q} & impl;                 // R16

  // pin level readback, analog pins forced low
  assign pin_rd = i_pin & ~ana_q & impl;                             // R10 R08

  ////////////////////////////////////////////////////////////////////////////
  // change notification

  // combinational compare works with the clock stopped
  // the request drops on a read of pin level or status, or when the pin returns to its captured level
  assign o_cn_irq = |((i_pin[30:0] ^ cn_cap_q) & cn_en & impl[30:0]); // R13 R14 R15 R20

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  // a ready drops while its half is held or the response waits
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
  assign wr_go         = aw_full_q & w_full_q & ~s_axi_bvalid;

  // capture address and data in either order, answer once both are held
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awaddr_q     <= 8'h00;
      aw_full_q    <= 1'b0;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      w_full_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      // both halves held: commit, free the holders and answer
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register updates from the bus
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_q     <= `GPC_RST_DIR;                                     // R05
      lat_q     <= `GPC_RST_ZERO;
      odc_q     <= `GPC_RST_ZERO;
      cnen_lo_q <= 16'h0000;
      cnen_hi_q <= 15'h0000;
      pu_lo_q   <= 16'h0000;
      pu_hi_q   <= 15'h0000;
      ana_q     <= `GPC_RST_ZERO;
      rmp_q     <= 26'h0000000;                                      // R19
    end else if (wr_go) begin
      // absent direction bits stay input so they never drive
      case (awaddr_q)
        `GPC_OFF_DIR:     dir_q <= merge(dir_q, wdata_q, wstrb_q) | ~impl; // R04 R08
        `GPC_OFF_LAT:     lat_q <= merge(lat_q, wdata_q, wstrb_q) & impl;  // R06
        `GPC_OFF_PIN:     lat_q <= merge(lat_q, wdata_q, wstrb_q) & impl;  // R07
        `GPC_OFF_ODC:     odc_q <= merge(odc_q, wdata_q, wstrb_q) & impl;  // R09
        `GPC_OFF_CNEN_LO: cnen_lo_q <= cnen_lo_wr[15:0];             // R15
        `GPC_OFF_CNEN_HI: cnen_hi_q <= cnen_hi_wr[14:0];             // R15
        `GPC_OFF_PU_LO:   pu_lo_q <= pu_lo_wr[15:0];                 // R16
        `GPC_OFF_PU_HI:   pu_hi_q <= pu_hi_wr[14:0];                 // R16
        `GPC_OFF_ANA:     ana_q <= merge(ana_q, wdata_q, wstrb_q) & impl;
        `GPC_OFF_RMP:     rmp_q <= rmp_wr[25:0];                     // R19
        default:          rmp_q <= rmp_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  // address refused while read data waits for rready
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & s_axi_arready;

  // registered read data, one cycle after the address is taken
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `GPC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      case (s_axi_araddr)
        `GPC_OFF_DIR:     s_axi_rdata <= dir_q & impl;               // R08
        `GPC_OFF_LAT:     s_axi_rdata <= lat_q & impl;               // R06 R08
        `GPC_OFF_PIN:     s_axi_rdata <= pin_rd;                     // R07 R10
        `GPC_OFF_ODC:     s_axi_rdata <= odc_q;
        `GPC_OFF_CNEN_LO: s_axi_rdata <= {16'h0000, cnen_lo_q};
        `GPC_OFF_CNEN_HI: s_axi_rdata <= {17'h00000, cnen_hi_q};
        `GPC_OFF_PU_LO:   s_axi_rdata <= {16'h0000, pu_lo_q};
        `GPC_OFF_PU_HI:   s_axi_rdata <= {17'h00000, pu_hi_q};
        `GPC_OFF_ANA:     s_axi_rdata <= ana_q;
        `GPC_OFF_RMP:     s_axi_rdata <= {6'h00, rmp_q};
        `GPC_OFF_CNSTAT:  s_axi_rdata <= {o_cn_irq, cn_cap_q};
        // unmapped or unaligned offsets answer zero with an error
        default:          s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // reading pin level or status rearms the change compare
  // rearm uses the level at the address edge, the same one a pin level read returns
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cn_cap_q <= 31'h00000000;
    end else if (rd_go && ((s_axi_araddr == `GPC_OFF_PIN) ||
                           (s_axi_araddr == `GPC_OFF_CNSTAT))) begin
      cn_cap_q <= i_pin[30:0];                                       // R20
    end
  end

endmodule // gpc_port

// ==== gpc_port_end.v ====
`timescale 1ns/100ps

// ==== gpc_port_monitor.sv ====
`timescale 1ns/100ps
`include "gpc_defines.vh"
module gpc_port_monitor (
  input logic        i_clk_sys,     // clock
  input logic        i_rst_n,       // reset
  input logic        s_axi_awvalid, // aw valid
  input logic        s_axi_awready, // aw ready
  input logic        s_axi_wvalid,  // w valid
  input logic        s_axi_wready,  // w ready
  input logic        s_axi_bvalid,  // b valid
  input logic        s_axi_arvalid, // ar valid
  input logic        s_axi_arready, // ar ready
  input logic        s_axi_rvalid,  // r valid
  input logic        s_axi_rready,  // r ready
  input logic [31:0] s_axi_rdata,   // read data
  input logic [31:0] i_pin,         // pins
  input logic [31:0] o_pin_oe,      // drive enables
  input logic [31:0] o_pin_pu,      // pull-ups
  input logic [31:0] i_per_en,      // peripheral enable
  input logic [31:0] i_per_drv,     // peripheral drive
  input logic [25:0] i_rmp_drv,     // remap drive
  input logic [31:0] o_per_in,      // to peripherals
  input logic [25:0] o_rmp_in       // to remapped
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // pin side
  reset_inputs_a: assert property ($rose(i_rst_n) |-> o_pin_oe == 32'h0)
    else $error("pin driven after reset");
  unimpl_off_a: assert property ((o_pin_oe & ~`GPC_IMPL_MASK) == 32'h0)
    else $error("absent pin driven");
  pullup_top_a: assert property (o_pin_pu[31] == 1'b0)
    else $error("pull-up beyond notify inputs");
  no_loop_a: assert property ((((o_per_in & ~i_pin) |
    (o_per_in & o_pin_oe & ~(i_per_en & i_per_drv) & ~{6'h00, i_rmp_drv})) == 32'h0))
    else $error("peripheral sees non-pin level");
  rmp_gate_a: assert property ((o_rmp_in & ~i_pin[25:0]) == 26'h0)
    else $error("remap input not from pin");
  ////////////////////////////////////////////////////////////////////////////////
  // bus side
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken under response");
endmodule // gpc_port_monitor

bind gpc_port gpc_port_monitor mon_u (.*);

// ==== gpc_pin_model.sv ====
`timescale 1ns/100ps
module gpc_pin_model (
  input  logic        i_clk_sys, // clock
  input  logic [31:0] i_out,     // port value
  input  logic [31:0] i_oe,      // port drive
  input  logic [31:0] i_pu,      // pull-ups
  input  logic [31:0] i_ext,     // outside value
  input  logic [31:0] i_ext_en,  // outside drive
  output logic [31:0] o_level    // pin level
);
  logic [31:0] last_q = 32'h0;
  // floating lines flip each cycle so a stale level never passes
  always @(posedge i_clk_sys) last_q <= o_level;
  // device drive, then outside drive, then weak pull-up or float
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
    | (~i_oe & ~i_ext_en & (i_pu | ~last_q));
endmodule // gpc_pin_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "gpc_defines.vh"
module tb_top;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, i_per_en, i_per_drv, i_per_out, ext, ext_en, v, d, m, a;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [25:0] i_rmp_drv, i_rmp_out;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_cn_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, i_pin, o_pin_out, o_pin_oe, o_pin_pu, o_per_in;
  wire  [25:0] o_rmp_in;
  int          fail_count, n_compared, cyc, seed;

  gpc_port dut_u (.*);
  gpc_pin_model pin_u (.i_clk_sys(i_clk_sys), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pin_pu), .i_ext(ext), .i_ext_en(ext_en), .o_level(i_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  // expected pin read and pull-up map
  function automatic [31:0] exp_pin(input [31:0] lat, dir, e, ana);
    return ((lat & ~dir) | (e & dir)) & ~ana & `GPC_IMPL_MASK;
  endfunction
  function automatic [31:0] exp_pu(input [31:0] lo, hi);
    return {1'b0, hi[14:0], lo[15:0]};
  endfunction
  task chk(input string nm, input [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task nap;
    @(negedge i_clk_sys);
  endtask
  // bus write, handshakes sampled mid-cycle and released after their edge
  task wr(input [7:0] ad, input [31:0] dt);
    logic aw, wt, bt;
    @(posedge i_clk_sys);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      nap;
      aw = s_axi_awvalid & s_axi_awready;
      wt = s_axi_wvalid & s_axi_wready;
      bt = s_axi_bvalid;
      @(posedge i_clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end while (!bt);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] ad, output [31:0] dt, output [1:0] rs);
    logic at, rt;
    @(posedge i_clk_sys);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      nap;
      at = s_axi_arvalid & s_axi_arready;
      rt = s_axi_rvalid;
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge i_clk_sys);
      if (at) s_axi_arvalid <= 1'b0;
    end while (!rt);
    s_axi_rready <= 1'b0;
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, i_per_en, i_per_drv, i_per_out, ext} = '0;
    {i_rmp_drv, i_rmp_out} = '0;
    s_axi_wstrb = 4'hF;
    ext_en = 32'hFFFFFFFF;
    seed = $urandom(32'h3C432A39);
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(`GPC_OFF_DIR, v, r);
    chk("dir reset", `GPC_RST_DIR & `GPC_IMPL_MASK, v);
    rd(`GPC_OFF_LAT, v, r);
    chk("lat reset", `GPC_RST_ZERO, v);
    chk("oe reset", `GPC_RST_ZERO, o_pin_oe);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      m = $urandom;
      a = $urandom & m;
      ext <= $urandom;
      i_per_drv <= $urandom;
      i_rmp_drv <= d[25:0];
      wr(`GPC_OFF_ANA, a);
      wr(`GPC_OFF_LAT, d);
      wr(`GPC_OFF_DIR, m);
      rd(`GPC_OFF_LAT, v, r);
      chk("lat", d & `GPC_IMPL_MASK, v);
      rd(`GPC_OFF_PIN, v, r);
      chk("pin", exp_pin(d, m, ext, a), v);
      chk("oe", ~m, o_pin_oe);
      chk("rmp idle", 32'h0, {6'h0, o_rmp_in});
      wr(`GPC_OFF_PIN, m);
      rd(`GPC_OFF_LAT, v, r);
      chk("pin write", m, v);
    end
    $display("test port done");
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    nap;
    chk("oe rereset", `GPC_RST_ZERO, o_pin_oe);
    rd(`GPC_OFF_DIR, v, r);
    chk("dir rereset", `GPC_RST_DIR & `GPC_IMPL_MASK, v);
    $display("test rereset done");
    wr(`GPC_OFF_ANA, 32'h0);
    wr(`GPC_OFF_DIR, 32'h0);
    wr(`GPC_OFF_ODC, 32'hFFFFFFFF);
    wr(`GPC_OFF_LAT, d);
    nap;
    chk("od oe", ~d, o_pin_oe);
    chk("od low", 32'h0, o_pin_out & o_pin_oe);
    wr(`GPC_OFF_ODC, 32'h0);
    i_per_en <= 32'hFFFFFFFF;
    i_per_drv <= 32'hFC000000;
    i_per_out <= m;
    nap;
    chk("idle per", 32'h03FFFFFF, o_pin_oe & 32'h03FFFFFF);
    chk("per loop", 32'h0, o_per_in & 32'h03FFFFFF);
    chk("per sees", m & 32'hFC000000, o_per_in & 32'hFC000000);
    @(posedge i_clk_sys);
    {i_per_en, i_per_drv, i_rmp_drv} <= '0;
    $display("test owner done");
    wr(`GPC_OFF_DIR, 32'hFFFFFFFF);
    wr(`GPC_OFF_RMP, 32'h1);
    nap;
    chk("rmp in", {31'h0, i_pin[0]}, {6'h0, o_rmp_in});
    @(posedge i_clk_sys);
    i_rmp_drv <= 26'h0000003;
    nap;
    chk("rmp owns", 32'h1, o_pin_oe & 32'h3);
    @(posedge i_clk_sys);
    i_rmp_drv <= 26'h0000000;
    wr(`GPC_OFF_PU_LO, d);
    wr(`GPC_OFF_PU_HI, m);
    nap;
    chk("pull-up", exp_pu(d, m), o_pin_pu);
    rd(`GPC_OFF_CNSTAT, v, r);
    wr(`GPC_OFF_CNEN_LO, 32'h1);
    nap;
    chk("cn quiet", 32'h0, {31'h0, o_cn_irq});
    @(posedge i_clk_sys);
    ext <= ext ^ 32'h2;
    nap;
    chk("cn masked", 32'h0, {31'h0, o_cn_irq});
    @(posedge i_clk_sys);
    ext <= ext ^ 32'h1;
    nap;
    chk("cn change", 32'h1, {31'h0, o_cn_irq});
    rd(`GPC_OFF_CNSTAT, v, r);
    chk("cn status", 32'h1, {31'h0, v[31]});
    nap;
    chk("cn rearm", 32'h0, {31'h0, o_cn_irq});
    $display("test notify done");
    rd(8'h2C, v, r);
    chk("bad resp", {30'h0, `GPC_RESP_SLVERR}, {30'h0, r});
    chk("bad data", 32'h0, v);
    $display("test unmapped done");
    print_verdict;
  end
endmodule // tb_top
